// *** hw/spi_front_pkg.sv ***
// Shared constants and types for the serial flash front end
package spi_front_pkg;
    // Array geometry: 8 Mbit, byte addressed
    localparam int ADDR_W = 20;
    localparam int SECTOR_SHIFT = 12;
    localparam int BLOCK32_SHIFT = 15;
    localparam int BLOCK64_SHIFT = 16;
    // Status register layout
    localparam int ST_BUSY_BIT = 0;
    localparam int ST_WEL_BIT = 1;
    localparam int ST_AUTO_INC_BIT = 6;
    localparam int ST_LOCK_BIT = 7;
    localparam logic [7:0] ST_RESET = 8'h1c;
    localparam logic [7:0] ST_WR_MASK = 8'hbc;
    // Pin sample order {cs_n, hold_n, wp_n, sck, si} and its reset image
    localparam int PIN_W = 5;
    localparam logic [4:0] PIN_RESET = 5'h1c;
    localparam logic [2:0] LAST_BIT = 3'h7;
    // Erase granule selector
    typedef enum logic [1:0] {
        ERASE_SECTOR = 2'b00,
        ERASE_BLOCK32 = 2'b01,
        ERASE_BLOCK64 = 2'b10,
        ERASE_CHIP = 2'b11
    } erase_size_type;
endpackage

// *** hw/spi_pins_if.sv ***
// Synchronised pin levels and edges passed from the sampler to the core
`timescale 1ns/1ps
interface spi_pins_if;
    logic cs_n_lvl;
    logic cs_fall;
    logic cs_rise;
    logic hold_n_lvl;
    logic wp_n_lvl;
    logic sck_lvl;
    logic sck_rise;
    logic sck_fall;
    logic si_lvl;
    modport sampler (output cs_n_lvl, cs_fall, cs_rise, hold_n_lvl, wp_n_lvl, sck_lvl, sck_rise, sck_fall, si_lvl);
    modport core (input cs_n_lvl, cs_fall, cs_rise, hold_n_lvl, wp_n_lvl, sck_lvl, sck_rise, sck_fall, si_lvl);
endinterface

// *** hw/spi_pin_sampler.sv ***
// Two-flop synchroniser and edge finder for the serial pins
`timescale 1ns/1ps
module spi_pin_sampler (
    input wire logic core_clk_in,
    input wire logic rst_n_in,
    input wire logic [spi_front_pkg::PIN_W-1:0] pins_raw_in,
    spi_pins_if.sampler pins
);
    import spi_front_pkg::*;

    logic [PIN_W-1:0] meta_q;
    logic [PIN_W-1:0] sync_q;
    logic [PIN_W-1:0] prev_q;

    // First stage feeds only the second; edges come from stages two and three
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            meta_q <= PIN_RESET;
            sync_q <= PIN_RESET;
            prev_q <= PIN_RESET;
        end else begin
            meta_q <= pins_raw_in;
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end

    // Edges of the serial clock are found the same way in either idle level
    assign pins.cs_n_lvl = sync_q[4];
    assign pins.hold_n_lvl = sync_q[3];
    assign pins.wp_n_lvl = sync_q[2];
    assign pins.sck_lvl = sync_q[1];
    assign pins.si_lvl = sync_q[0];
    assign pins.cs_fall = prev_q[4] & ~sync_q[4];
    assign pins.cs_rise = ~prev_q[4] & sync_q[4];
    assign pins.sck_rise = ~prev_q[1] & sync_q[1];
    assign pins.sck_fall = prev_q[1] & ~sync_q[1];

    a_sck_edge_rise: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        pins.sck_rise |-> (pins.sck_lvl && !$past(pins.sck_lvl)))
        else $error("serial clock rise flagged without a low to high change");
endmodule

// *** hw/spi_flash_serial_front_end.sv ***
// Serial front end of an SPI flash: framing, shifting, pause, protect, busy pin
//
// Overview of operation
// - Works with clock idle low or idle high
// - Serial input captured on clock rising edge
// - Outside ready/busy mode, serial output changes only after falling edge
// - New sequence starts on select falling edge
// - Output pin shows ready/busy during auto-increment
// - Pause freezes sequence without losing its state
// - Write-protect pin enables the lock bit
// - Array split into aligned 4K/32K/64K granules
// - Pause starts only with select and clock low
// - Deselect while paused resets serial logic
// - Locked status write refused when protect low
// - Status bit 0 reports internal write busy
`timescale 1ns/1ps
module spi_flash_serial_front_end (
    input wire logic core_clk_in,
    input wire logic rst_n_in,
    input wire logic sck_in,
    input wire logic si_in,
    input wire logic cs_n_in,
    input wire logic hold_n_in,
    input wire logic wp_n_in,
    output logic so_out,
    output logic so_oe_out,
    output logic seq_start_out,
    output logic seq_end_out,
    output logic rx_valid_out,
    output logic rx_first_out,
    output logic [7:0] rx_byte_out,
    input wire logic tx_enable_in,
    input wire logic [7:0] tx_byte_in,
    input wire logic busy_in,
    input wire logic wel_in,
    input wire logic auto_increment_program_in,
    input wire logic so_busy_enable_in,
    input wire logic write_status_command_in,
    input wire logic [7:0] status_wdata_in,
    output logic status_rejected_out,
    output logic [7:0] status_out,
    output logic protection_lock_bit_out,
    output logic paused_out,
    input wire logic [spi_front_pkg::ADDR_W-1:0] erase_addr_in,
    input wire spi_front_pkg::erase_size_type erase_size_in,
    output logic [spi_front_pkg::ADDR_W-1:0] erase_first_out,
    output logic [spi_front_pkg::ADDR_W-1:0] erase_last_out
);
    import spi_front_pkg::*;

    spi_pins_if pins ();

    logic paused_q;
    logic [2:0] bit_cnt_q;
    logic [7:0] rx_shift_q;
    logic [7:0] tx_q;
    logic first_q;
    logic so_q;
    logic busy_mode_q;
    logic data_mode_q;
    logic [7:0] status_q;
    logic active_rise;
    logic active_fall;
    logic status_accept;

    spi_pin_sampler sampler_inst (
        .core_clk_in(core_clk_in),
        .rst_n_in(rst_n_in),
        .pins_raw_in({cs_n_in, hold_n_in, wp_n_in, sck_in, si_in}),
        .pins(pins.sampler)
    );

    // Base of the aligned granule holding an address
    function automatic logic [ADDR_W-1:0] granule_base(input logic [ADDR_W-1:0] addr, input int shift);
        logic [ADDR_W-1:0] mask;
        mask = ~((ADDR_W'(1) << shift) - ADDR_W'(1));
        return addr & mask;
    endfunction

    // Top address of the same granule
    function automatic logic [ADDR_W-1:0] granule_top(input logic [ADDR_W-1:0] addr, input int shift);
        logic [ADDR_W-1:0] mask;
        mask = (ADDR_W'(1) << shift) - ADDR_W'(1);
        return addr | mask;
    endfunction

    // Clock edges count only while selected and not paused
    assign active_rise = pins.sck_rise & ~pins.cs_n_lvl & ~paused_q;
    assign active_fall = pins.sck_fall & ~pins.cs_n_lvl & ~paused_q;

    // Pause entry needs select low and clock low; exit waits for clock low or deselect
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            paused_q <= 1'b0;
        end else if (!paused_q) begin
            if (!pins.cs_n_lvl && !pins.hold_n_lvl && !pins.sck_lvl) begin
                paused_q <= 1'b1;
            end
        end else if (pins.hold_n_lvl && (!pins.sck_lvl || pins.cs_n_lvl)) begin
            paused_q <= 1'b0;
        end
    end

    // Bit counter and input shifter; deselect clears them even when paused
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            bit_cnt_q <= 3'h0;
            rx_shift_q <= 8'h00;
        end else if (pins.cs_n_lvl || pins.cs_fall) begin
            bit_cnt_q <= 3'h0;
            rx_shift_q <= 8'h00;
        end else if (active_rise) begin
            bit_cnt_q <= bit_cnt_q + 3'h1;
            rx_shift_q <= {rx_shift_q[6:0], pins.si_lvl};
        end
    end

    // Byte hand-off; transmit byte is taken at the same boundary
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rx_valid_out <= 1'b0;
            rx_first_out <= 1'b0;
            rx_byte_out <= 8'h00;
            tx_q <= 8'h00;
            first_q <= 1'b0;
        end else begin
            rx_valid_out <= 1'b0;
            if (pins.cs_fall) begin
                first_q <= 1'b1;
            end else if (active_rise && bit_cnt_q == LAST_BIT) begin
                rx_valid_out <= 1'b1;
                rx_first_out <= first_q;
                rx_byte_out <= {rx_shift_q[6:0], pins.si_lvl};
                tx_q <= tx_byte_in;
                first_q <= 1'b0;
            end
        end
    end

    // Sequence framing pulses; the end of a sequence relies on select rising
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            seq_start_out <= 1'b0;
            seq_end_out <= 1'b0;
        end else begin
            seq_start_out <= pins.cs_fall;
            seq_end_out <= pins.cs_rise;
        end
    end

    // Output data moves only on a falling edge; busy mode overrides
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            so_q <= 1'b1;
            busy_mode_q <= 1'b0;
            data_mode_q <= 1'b0;
        end else begin
            data_mode_q <= ~pins.cs_n_lvl & tx_enable_in;
            busy_mode_q <= so_busy_enable_in & auto_increment_program_in & ~(~pins.cs_n_lvl & tx_enable_in);
            if (so_busy_enable_in && auto_increment_program_in && !(!pins.cs_n_lvl && tx_enable_in)) begin
                so_q <= ~busy_in;
            end else if (active_fall) begin
                so_q <= tx_q[LAST_BIT - bit_cnt_q];
            end
        end
    end

    // Floats when paused or deselected, unless showing ready/busy
    assign so_out = so_q;
    assign so_oe_out = busy_mode_q | (data_mode_q & ~paused_q);
    assign paused_out = paused_q;

    // Lock bit counts only while the protect pin is low
    assign status_accept = pins.wp_n_lvl | ~status_q[ST_LOCK_BIT];

    // Status register: writable bits guarded, live bits follow the core
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            status_q <= ST_RESET;
            status_rejected_out <= 1'b0;
        end else begin
            status_rejected_out <= write_status_command_in & ~status_accept;
            if (write_status_command_in && status_accept) begin
                status_q[7:2] <= (status_wdata_in[7:2] & ST_WR_MASK[7:2]) | (status_q[7:2] & ~ST_WR_MASK[7:2]);
            end
            status_q[ST_BUSY_BIT] <= busy_in;
            status_q[ST_WEL_BIT] <= wel_in;
            status_q[ST_AUTO_INC_BIT] <= auto_increment_program_in;
        end
    end

    assign status_out = status_q;
    assign protection_lock_bit_out = status_q[ST_LOCK_BIT];

    // Aligned erase range; registered so outputs come from flops
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            erase_first_out <= '0;
            erase_last_out <= '0;
        end else begin
            unique case (erase_size_in)
                ERASE_SECTOR: begin
                    erase_first_out <= granule_base(erase_addr_in, SECTOR_SHIFT);
                    erase_last_out <= granule_top(erase_addr_in, SECTOR_SHIFT);
                end
                ERASE_BLOCK32: begin
                    erase_first_out <= granule_base(erase_addr_in, BLOCK32_SHIFT);
                    erase_last_out <= granule_top(erase_addr_in, BLOCK32_SHIFT);
                end
                ERASE_BLOCK64: begin
                    erase_first_out <= granule_base(erase_addr_in, BLOCK64_SHIFT);
                    erase_last_out <= granule_top(erase_addr_in, BLOCK64_SHIFT);
                end
                ERASE_CHIP: begin
                    erase_first_out <= '0;
                    erase_last_out <= '1;
                end
            endcase
        end
    end

    a_byte_on_rise: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        (active_rise && bit_cnt_q == 3'h7 && !pins.cs_fall) |=> rx_valid_out)
        else $error("eighth rising edge did not deliver a byte");

    a_so_after_fall: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        (!busy_mode_q && so_q != $past(so_q)) |-> $past(active_fall))
        else $error("serial output changed without a falling edge");

    a_start_on_select: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        pins.cs_fall |=> (seq_start_out && bit_cnt_q == 3'h0))
        else $error("select falling edge did not open a sequence");

    a_busy_pin_level: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        (so_busy_enable_in && auto_increment_program_in && pins.cs_n_lvl)
        |=> (so_oe_out && so_out == !$past(busy_in)))
        else $error("ready/busy level not shown on serial output");

    a_pause_freeze: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        (paused_q && !pins.cs_n_lvl)
        |=> (bit_cnt_q == $past(bit_cnt_q) && rx_shift_q == $past(rx_shift_q)))
        else $error("serial state moved while paused");

    // Output is looked at in the entry cycle only: a legal resume may follow at once
    a_pause_entry: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        (!pins.cs_n_lvl && !pins.hold_n_lvl && !pins.sck_lvl) |=> (paused_q && (!so_oe_out || busy_mode_q)))
        else $error("pause not entered with select and clock low");

    a_deselect_paused: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        (paused_q && pins.cs_n_lvl && !pins.hold_n_lvl) |=> (paused_q && bit_cnt_q == 3'h0))
        else $error("deselect during pause did not reset or left pause");

    // Bit 6 is live and may move on its own, so only the writable bits are held
    a_lock_reject: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        (write_status_command_in && !pins.wp_n_lvl && status_q[ST_LOCK_BIT])
        |=> (status_rejected_out && {status_q[7], status_q[5:2]} == $past({status_q[7], status_q[5:2]})))
        else $error("locked status write was not refused");

    a_busy_status: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        busy_in |=> status_out[0] ##1 (status_out[0] == $past(busy_in)))
        else $error("status bit 0 does not follow internal busy");

    a_idle_quiet: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        (pins.cs_n_lvl && $past(pins.cs_n_lvl) && !so_busy_enable_in) |=> (!rx_valid_out && !so_oe_out))
        else $error("deselected device reacted or drove output");
endmodule

// *** tb/spi_master_model.sv ***
// Behavioural bus master that drives the serial pins of the flash front end
`timescale 1ns/1ps
module spi_master_model (
    input wire logic core_clk_in,
    input wire logic mode3_in,
    input wire logic so_in,
    output logic sck_out,
    output logic si_out,
    output logic cs_n_out,
    output logic hold_n_out
);
    // Pins idle deselected with the clock low until the first sequence
    initial begin
        sck_out = 1'b0;
        si_out = 1'b0;
        cs_n_out = 1'b1;
        hold_n_out = 1'b1;
    end

    // Half a link period is four core cycles, 80 ns a full period
    task automatic half();
        repeat (4) @(posedge core_clk_in);
        #1;
    endtask

    // Clock parked at its idle level before select falls
    task automatic select();
        sck_out = mode3_in;
        half();
        cs_n_out = 1'b0;
        half();
    endtask

    // Data set up while the clock is low, reply sampled at the rise
    task automatic bits(input logic [7:0] tx, input int n, output logic [7:0] rx);
        rx = 8'h00;
        for (int i = 0; i < n; i++) begin
            sck_out = 1'b0;
            si_out = tx[7-i];
            half();
            sck_out = 1'b1;
            rx = {rx[6:0], so_in};
            half();
        end
    endtask

    // Return to idle level, then release select; it stays low until here
    task automatic deselect();
        sck_out = mode3_in;
        half();
        cs_n_out = 1'b1;
        half();
    endtask

    // Pause only lowered while the clock is low
    task automatic pause();
        sck_out = 1'b0;
        half();
        hold_n_out = 1'b0;
        half();
    endtask

    task automatic resume();
        hold_n_out = 1'b1;
        half();
    endtask
endmodule

// *** tb/testbench.sv ***
// Self-checking bench for the serial flash front end
`timescale 1ns/1ps
module testbench;
    import spi_front_pkg::*;
    logic core_clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic sck_in, si_in, cs_n_in, hold_n_in, so_out, so_oe_out, seq_start_out, seq_end_out;
    logic rx_valid_out, rx_first_out, status_rejected_out, protection_lock_bit_out, paused_out;
    logic [7:0] rx_byte_out, status_out;
    logic wp_n_in = 1'b1, tx_enable_in = 1'b0, busy_in = 1'b0, wel_in = 1'b0, mode3 = 1'b0;
    logic auto_increment_program_in = 1'b0, so_busy_enable_in = 1'b0, write_status_command_in = 1'b0;
    logic [7:0] tx_byte_in = 8'h00, status_wdata_in = 8'h00, rx_last, r;
    logic [19:0] erase_addr_in = 20'h12345, erase_first_out, erase_last_out;
    erase_size_type erase_size_in = ERASE_SECTOR;
    logic so_float = 1'b0, first_last;
    int miscompares = 0, tests_run = 0, cycles = 0, rx_count = 0, n0;
    logic [19:0] ef [4] = '{20'h12000, 20'h10000, 20'h10000, 20'h00000};
    logic [19:0] el [4] = '{20'h12fff, 20'h17fff, 20'h1ffff, 20'hfffff};
    logic [7:0] sw [4] = '{8'hff, 8'h00, 8'h00, 8'h84};
    logic [7:0] se [4] = '{8'hbc, 8'hbc, 8'h00, 8'h84};
    logic [3:0] sp = 4'b0101;
    logic [3:0] sr = 4'b0010;

    always #5 core_clk_in = ~core_clk_in;

    // Released output shows a toggling level, never a stale bit
    always @(posedge core_clk_in) so_float <= ~so_float;

    spi_master_model m (.core_clk_in, .mode3_in(mode3), .so_in(so_oe_out ? so_out : so_float),
        .sck_out(sck_in), .si_out(si_in), .cs_n_out(cs_n_in), .hold_n_out(hold_n_in));

    spi_flash_serial_front_end dut (.core_clk_in, .rst_n_in, .sck_in, .si_in, .cs_n_in, .hold_n_in,
        .wp_n_in, .so_out, .so_oe_out, .seq_start_out, .seq_end_out, .rx_valid_out, .rx_first_out,
        .rx_byte_out, .tx_enable_in, .tx_byte_in, .busy_in, .wel_in, .auto_increment_program_in,
        .so_busy_enable_in, .write_status_command_in, .status_wdata_in, .status_rejected_out,
        .status_out, .protection_lock_bit_out, .paused_out, .erase_addr_in, .erase_size_in,
        .erase_first_out, .erase_last_out);

    // Received bytes caught in the single cycle that the pulse stands
    always @(posedge core_clk_in) begin
        if (rx_valid_out === 1'b1) begin
            rx_count++;
            rx_last = rx_byte_out;
            first_last = rx_first_out;
        end
    end

    task automatic tick(input int n);
        repeat (n) @(posedge core_clk_in);
        #1;
    endtask

    task automatic check(input string what, input logic [19:0] exp, input logic [19:0] got);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic conclude();
        $display("Comparisons %0d, mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    // A hang is cut short well past the expected run length
    always @(posedge core_clk_in) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            conclude();
        end
    end

    initial begin
        tick(12);
        rst_n_in = 1'b1;
        tick(3);
        check("status", 8'h1c, status_out);
        check("oe", 1'b0, so_oe_out);
        // Both clock idle levels, byte framing, reply on the falling edge
        for (int k = 0; k < 2; k++) begin
            mode3 = k[0];
            tx_enable_in = 1'b1;
            tx_byte_in = 8'hc3;
            n0 = rx_count;
            m.select();
            m.bits(8'ha5, 8, r);
            check("rx", 8'ha5, rx_last);
            check("first", 1'b1, first_last);
            m.bits(8'h3c, 8, r);
            check("tx", 8'hc3, r);
            check("first", 1'b0, first_last);
            m.bits(8'h55, 4, r);
            m.deselect();
            tx_enable_in = 1'b0;
            m.bits(8'hff, 8, r);
            check("count", 20'd2, 20'(rx_count - n0));
            check("oe", 1'b0, so_oe_out);
        end
        // Pause in mid-byte keeps the partial byte; data out is asked for so the float is seen
        mode3 = 1'b0;
        tx_enable_in = 1'b1;
        m.select();
        m.bits(8'h96, 4, r);
        check("oe", 1'b1, so_oe_out);
        m.pause();
        check("paused", 1'b1, paused_out);
        check("oe", 1'b0, so_oe_out);
        m.resume();
        m.bits(8'h60, 4, r);
        check("rx", 8'h96, rx_last);
        m.bits(8'h00, 2, r);
        m.pause();
        m.deselect();
        check("paused", 1'b1, paused_out);
        m.resume();
        check("paused", 1'b0, paused_out);
        m.select();
        m.bits(8'h5a, 8, r);
        check("rx", 8'h5a, rx_last);
        check("first", 1'b1, first_last);
        m.deselect();
        // Status writes under every protect and lock combination
        for (int k = 0; k < 4; k++) begin
            wp_n_in = sp[k];
            tick(4);
            write_status_command_in = 1'b1;
            status_wdata_in = sw[k];
            tick(1);
            write_status_command_in = 1'b0;
            check("status", se[k], status_out);
            check("rejected", sr[k], status_rejected_out);
            check("lock", se[k][7], protection_lock_bit_out);
        end
        // Live status bits and ready/busy on the output pin
        busy_in = 1'b1;
        wel_in = 1'b1;
        auto_increment_program_in = 1'b1;
        so_busy_enable_in = 1'b1;
        tick(3);
        check("status", 8'hc7, status_out);
        check("oe", 1'b1, so_oe_out);
        check("so", 1'b0, so_out);
        busy_in = 1'b0;
        tick(3);
        check("status", 8'hc6, status_out);
        check("so", 1'b1, so_out);
        // Aligned erase ranges for every granule
        for (int k = 0; k < 4; k++) begin
            erase_size_in = erase_size_type'(k);
            tick(2);
            check("first", ef[k], erase_first_out);
            check("last", el[k], erase_last_out);
        end
        conclude();
    end
endmodule
